// ---- logic/dsfi_pkg.sv ----
// constants shared by the serial frame input block
// assumes a single 40 MHz sampling clock and an external shift clock
package dsfi_pkg;
   localparam int unsigned DSFI_WORD_W     = 16;
   localparam int unsigned DSFI_UPDATE_CNT = 16;
   localparam int unsigned DSFI_ABORT_CNT  = 15;
   localparam int unsigned DSFI_CNT_W      = 6;
   localparam logic [15:0] DSFI_WORD_RST   = 16'h0000;
   localparam logic [3:0]  DSFI_MODE_RST   = 4'h0;
   localparam logic [7:0]  DSFI_PD_RST     = 8'h00;
   localparam logic [11:0] DSFI_VAL_RST    = 12'h000;
   localparam int unsigned DSFI_SYNC_STAGES = 2;
   typedef enum logic [1:0] {
      DSFI_IDLE  = 2'b00,
      DSFI_SHIFT = 2'b01,
      DSFI_DONE  = 2'b11
   } dsfi_state_t;
endpackage

// ---- logic/dsfi_buf2.sv ----
// two-entry valid/ready buffer for committed words
// assumes both sides on the same clock
`timescale 1ns/100ps
module dsfi_buf2 #(
   parameter int unsigned W = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   logic [W-1:0] mem_r [2];
   logic         rd_r;
   logic         wr_r;
   logic [1:0]   cnt_r;
   wire          push = in_valid_i && (cnt_r != 2'h2);
   wire          pop  = out_ready_i && (cnt_r != 2'h0);
   assign in_ready_o  = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o  = mem_r[rd_r];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         rd_r     <= 1'b0;
         wr_r     <= 1'b0;
         cnt_r    <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wr_r] <= in_data_i;
            wr_r        <= ~wr_r;
         end
         if (pop) begin
            rd_r <= ~rd_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ---- logic/dsfi_top.sv ----
// serial frame input of an eight-channel dac: shift, commit, chain out
// assumes REF_CLK_I at least four times faster than the shift clock
`timescale 1ns/100ps
// What this block does
// - while strobe low, capture data bit on every falling shift-clock edge
// - strobe rise after sixteenth falling edge commits word to the dac
// - strobe rise before fifteenth falling edge aborts, word discarded
// - chain output carries data only after more than sixteen clocks low
// - committed word selects mode and channel register value, power-down only in mode F
module dsfi_top
   import dsfi_pkg::*;
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RESETN_I,
   input  wire logic        SYNC_N_I,
   input  wire logic        SCLK_I,
   input  wire logic        DIN_I,
   output logic             DOUT_O,
   output logic             WORD_VALID_O,
   input  wire logic        WORD_READY_I,
   output logic [15:0]      WORD_O,
   output logic [3:0]       MODE_O,
   output logic [7:0]       PD_O,
   output logic [11:0]      VALUE_O,
   output logic             ABORT_O,
   output logic             OVERRUN_O
);
   // ****************************************************
   // input synchronisers
   // ****************************************************
   logic [1:0] sync_s_r;
   logic [1:0] sclk_s_r;
   logic [1:0] din_s_r;
   logic       sclk_d_r;
   logic       sync_d_r;
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sync_s_r <= 2'h3;
         sclk_s_r <= 2'h3;
         din_s_r  <= 2'h0;
         sclk_d_r <= 1'b1;
         sync_d_r <= 1'b1;
      end else begin
         sync_s_r <= {sync_s_r[0], SYNC_N_I};
         sclk_s_r <= {sclk_s_r[0], SCLK_I};
         din_s_r  <= {din_s_r[0], DIN_I};
         sclk_d_r <= sclk_s_r[1];
         sync_d_r <= sync_s_r[1];
      end
   end
   wire sync_n   = sync_s_r[1];
   wire sclk_fall = sclk_d_r && !sclk_s_r[1];
   wire sync_fall = sync_d_r && !sync_n;
   wire sync_rise = !sync_d_r && sync_n;
   wire din_bit  = din_s_r[1];
   // ****************************************************
   // frame control
   // ****************************************************
   dsfi_state_t          state_r;
   dsfi_state_t          state_nxt;
   logic [DSFI_CNT_W-1:0] cnt_r;
   logic [15:0]          shreg_r;
   logic                 dout_r;
   logic                 abort_r;
   logic                 ovr_r;
   logic                 commit_r;
   logic [15:0]          commit_word_r;
   wire shifting  = (state_r != DSFI_IDLE) && !sync_n;
   wire take_bit  = shifting && sclk_fall;
   wire full_word = (cnt_r >= DSFI_CNT_W'(DSFI_UPDATE_CNT));
   wire early     = (cnt_r < DSFI_CNT_W'(DSFI_ABORT_CNT));
   wire do_commit = sync_rise && (state_r != DSFI_IDLE) && full_word;
   wire do_abort  = sync_rise && (state_r != DSFI_IDLE) && !full_word;
   wire chain_on  = full_word;
   wire buf_ready;
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DSFI_IDLE:  if (sync_fall) state_nxt = DSFI_SHIFT;
         DSFI_SHIFT: if (sync_n) state_nxt = DSFI_IDLE;
                     else if (full_word) state_nxt = DSFI_DONE;
         DSFI_DONE:  if (sync_n) state_nxt = DSFI_IDLE;
         default:    state_nxt = DSFI_IDLE;
      endcase
   end
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_r <= DSFI_IDLE;
         cnt_r   <= '0;
         shreg_r <= DSFI_WORD_RST;
         dout_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (sync_fall) begin
            cnt_r <= '0;
         end else if (take_bit && !cnt_r[DSFI_CNT_W-1]) begin
            cnt_r <= cnt_r + DSFI_CNT_W'(1);
         end
         if (take_bit) begin
            shreg_r <= {shreg_r[14:0], din_bit};
            // oldest bit leaves only once a whole word sits inside
            dout_r  <= chain_on ? shreg_r[15] : 1'b0;
         end else if (sync_n) begin
            dout_r  <= 1'b0;
         end
      end
   end
   // ****************************************************
   // commit, abort and word decode
   // ****************************************************
   // an abort between the fifteenth and sixteenth edge is also discarded:
   // no update without a whole word
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         commit_r      <= 1'b0;
         commit_word_r <= DSFI_WORD_RST;
         abort_r       <= 1'b0;
         ovr_r         <= 1'b0;
      end else begin
         commit_r <= do_commit;
         abort_r  <= do_abort && early;
         if (do_commit) begin
            commit_word_r <= shreg_r;
         end
         // sticky: set wins, only reset clears
         ovr_r <= ovr_r | (commit_r && !buf_ready);
      end
   end
   logic        bvalid;
   logic [15:0] bdata;
   // pop only when the output stage takes the word, so none is sent twice;
   // while stalled the output stage and both entries hold three words
   dsfi_buf2 #(.W(DSFI_WORD_W)) u_buf (
      .clk_i       (REF_CLK_I),
      .rst_n_i     (RESETN_I),
      .in_valid_i  (commit_r),
      .in_ready_o  (buf_ready),
      .in_data_i   (commit_word_r),
      .out_valid_o (bvalid),
      .out_ready_i (!WORD_VALID_O || WORD_READY_I),
      .out_data_o  (bdata)
   );
   wire take_out = bvalid && (!WORD_VALID_O || WORD_READY_I);
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         WORD_VALID_O <= 1'b0;
         WORD_O       <= DSFI_WORD_RST;
         MODE_O       <= DSFI_MODE_RST;
         PD_O         <= DSFI_PD_RST;
         VALUE_O      <= DSFI_VAL_RST;
      end else begin
         if (take_out) begin
            WORD_VALID_O <= 1'b1;
            WORD_O       <= bdata;
            MODE_O       <= bdata[15:12];
            VALUE_O      <= bdata[11:0];
            PD_O         <= (bdata[15:12] == 4'hF) ?
                            bdata[7:0] : PD_O;
         end else if (WORD_READY_I) begin
            WORD_VALID_O <= 1'b0;
         end
      end
   end
   assign DOUT_O    = dout_r;
   assign ABORT_O   = abort_r;
   assign OVERRUN_O = ovr_r;
   // ****************************************************
   // checks
   // ****************************************************
   a_commit_needs_16: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      commit_r |-> $past(cnt_r) >= DSFI_CNT_W'(DSFI_UPDATE_CNT))
      else $error("commit without sixteen edges");
   a_abort_no_commit: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      abort_r |-> !commit_r && $past(cnt_r) < DSFI_CNT_W'(DSFI_ABORT_CNT))
      else $error("aborted frame committed");
   a_shift_on_fall: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      take_bit |=> shreg_r[0] == $past(din_bit))
      else $error("bit not captured");
   a_chain_quiet: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (take_bit && !chain_on) |=> !DOUT_O)
      else $error("chain output active too early");
   a_chain_delay: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (take_bit && chain_on) |=> DOUT_O == $past(shreg_r[15]))
      else $error("chain output not sixteen-delayed");
   a_commit_data: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      do_commit |=> commit_word_r == $past(shreg_r))
      else $error("committed word wrong");
   a_word_decode: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      take_out |=> MODE_O == WORD_O[15:12] && VALUE_O == WORD_O[11:0])
      else $error("word fields wrong");
   a_idle_on_high: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      sync_rise |=> state_r == DSFI_IDLE)
      else $error("frame not closed by strobe rise");
   a_abort_single: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      ABORT_O |=> !ABORT_O)
      else $error("abort pulse longer than one cycle");
   a_no_word_early: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (sync_rise && cnt_r < DSFI_CNT_W'(DSFI_UPDATE_CNT)) |=> !commit_r)
      else $error("short frame committed");
   a_valid_held: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (WORD_VALID_O && !WORD_READY_I) |=> WORD_VALID_O && $stable(WORD_O))
      else $error("stalled word dropped or changed");
   a_dout_idle: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      sync_n |=> !DOUT_O)
      else $error("chain output active outside frame");
   a_pd_hold: assert property (
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (take_out && bdata[15:12] != 4'hF) |=> $stable(PD_O))
      else $error("power-down field changed by other mode");
endmodule

// ---- dv/dsfi_host.sv ----
// host model: drives frame strobe, shift clock and serial data
// assumes REF_CLK_I at 25 ns; one shift clock period is 8 of its cycles
`timescale 1ns/100ps
module dsfi_host (
   input  wire logic clk_i,
   input  wire logic dout_i,
   output logic      sync_n_o,
   output logic      sclk_o,
   output logic      din_o
);
   logic [39:0] dout_cap;
   initial begin
      sync_n_o = 1'b1;
      sclk_o   = 1'b1;
      din_o    = 1'b0;
      dout_cap = '0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // msb first; shift clock stands high outside frames
   // chain output is sampled just before each falling edge and once at end
   task automatic frame(input int n, input logic [31:0] d);
      sync_n_o <= 1'b0;
      wait_clk(4);
      for (int i = n - 1; i >= 0; i--) begin
         din_o <= d[i];
         wait_clk(4);
         dout_cap <= {dout_cap[38:0], dout_i};
         sclk_o   <= 1'b0;
         wait_clk(4);
         sclk_o <= 1'b1;
      end
      wait_clk(8);
      dout_cap <= {dout_cap[38:0], dout_i};
      sync_n_o <= 1'b1;
      din_o    <= ~din_o;
      wait_clk(4);
   endtask
endmodule

// ---- dv/tb_dac_serial_frame_input.sv ----
// self-checking bench for the serial frame input block
// assumes dsfi_host as the far side; no checker, assertions sit in design
`timescale 1ns/100ps
module tb_dac_serial_frame_input;
   import dsfi_pkg::*;
   typedef struct {
      int n; logic [31:0] d; int words; int aborts; logic [39:0] exp;
   } dsfi_row_t;
   logic             ref_clk_i;
   logic             resetn_i;
   logic             word_ready_i;
   wire logic        sync_n, sclk, din, dout, word_valid, abort, overrun;
   wire logic [15:0] word;
   wire logic [3:0]  mode;
   wire logic [7:0]  pd;
   wire logic [11:0] value;
   int               n_mismatch = 0;
   int               checked = 0;
   int               cycles = 0;
   int               n_abort = 0;
   logic [39:0]      got_q[$];
   // expected word as {mode, pd, value, word}; pd holds unless mode is F
   dsfi_row_t rows[8] = '{
      '{16, 32'h0000A5C3, 1, 0, 40'hA_00_5C3_A5C3},
      '{16, 32'h0000F0AB, 1, 0, 40'hF_AB_0AB_F0AB},
      '{16, 32'h00000000, 1, 0, 40'h0_AB_000_0000},
      '{0,  32'h00000000, 0, 1, 40'h0},
      '{8,  32'h0000005A, 0, 1, 40'h0},
      '{14, 32'h00001234, 0, 1, 40'h0},
      '{15, 32'h00001234, 0, 0, 40'h0},
      '{20, 32'h000B1234, 1, 0, 40'h1_AB_234_1234}};
   // ****************************************************
   // clock, instances, monitor
   // ****************************************************
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   dsfi_host dsfi_host_inst (.clk_i(ref_clk_i), .dout_i(dout),
      .sync_n_o(sync_n), .sclk_o(sclk), .din_o(din));
   dsfi_top dsfi_top_inst (.REF_CLK_I(ref_clk_i), .RESETN_I(resetn_i),
      .SYNC_N_I(sync_n), .SCLK_I(sclk), .DIN_I(din), .DOUT_O(dout),
      .WORD_VALID_O(word_valid), .WORD_READY_I(word_ready_i),
      .WORD_O(word), .MODE_O(mode), .PD_O(pd), .VALUE_O(value),
      .ABORT_O(abort), .OVERRUN_O(overrun));
   always @(posedge ref_clk_i) begin
      cycles++;
      if (abort === 1'b1)
         n_abort++;
      if (word_valid === 1'b1 && word_ready_i === 1'b1)
         got_q.push_back({mode, pd, value, word});
      if (cycles > 12000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic chk(input logic [39:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************************
   // table rows, then stall and reset cases
   // ****************************************************
   initial begin
      resetn_i     = 1'b0;
      word_ready_i = 1'b1;
      repeat (16) @(posedge ref_clk_i);
      chk({dout, word_valid, abort, overrun}, 40'h0, "reset outputs");
      resetn_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      foreach (rows[i]) begin
         got_q.delete();
         n_abort = 0;
         dsfi_host_inst.frame(rows[i].n, rows[i].d);
         repeat (12) @(posedge ref_clk_i);
         chk(got_q.size(), rows[i].words, "word count");
         chk(n_abort, rows[i].aborts, "abort pulses");
         if (rows[i].words == 1)
            chk(got_q[0], rows[i].exp, "word fields");
         if (rows[i].n == 20)
            chk(dsfi_host_inst.dout_cap[20:0],
               {17'h0, rows[i].d[19:16]}, "chain out");
      end
      // receiver stalls: three words kept, the fourth one is lost
      got_q.delete();
      word_ready_i <= 1'b0;
      for (int k = 0; k < 4; k++)
         dsfi_host_inst.frame(16, 32'h00001230 + k);
      repeat (12) @(posedge ref_clk_i);
      chk(overrun, 1'b1, "overrun flag");
      chk(word_valid, 1'b1, "word held in stall");
      word_ready_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk(got_q.size(), 3, "drained count");
      chk(got_q[0][15:0], 16'h1230, "first kept word");
      chk(got_q[1][15:0], 16'h1231, "second kept word");
      chk(got_q[2][15:0], 16'h1232, "third kept word");
      chk(word_valid, 1'b0, "buffer empty");
      resetn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk(overrun, 1'b0, "overrun cleared by reset");
      resetn_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      stop_test();
   end
endmodule
